// ==== hw/irq_regs_pkg.sv ====
// constants for the interrupt shaping, dma start and power-down register bank
// assumes a 100 MHz system clock and byte addresses on the register port
package irq_regs_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned UFRAME_NS       = 125000;
  localparam int unsigned UFRAME_CYCLES   = UFRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_TICK_NS    = 10000;
  localparam int unsigned SLOW_CYCLES     = SLOW_TICK_NS / CLK_PERIOD_NS;

  localparam logic [15:0] EDGE_IRQ_SHAPE_OFS = 16'h0340;
  localparam logic [15:0] DMA_START_OFS      = 16'h0344;
  localparam logic [15:0] POWER_DOWN_OFS     = 16'h0354;

  localparam logic [31:0] EDGE_IRQ_SHAPE_RST  = 32'h0000_000f;
  localparam logic [31:0] EDGE_IRQ_SHAPE_WMSK = 32'hff00_ffff;
  localparam logic [31:0] DMA_START_RST       = 32'h0000_0000;
  localparam logic [31:0] DMA_START_WMSK      = 32'h0000_ffff;
  localparam logic [31:0] POWER_DOWN_RST      = 32'h03e8_1ba0;
  localparam logic [31:0] POWER_DOWN_WMSK     = 32'hffff_1c3f;

  localparam int unsigned MIN_WIDTH_LSB  = 24;
  localparam int unsigned PULSE_LEN_LSB  = 0;
  localparam int unsigned CLK_OFF_LSB    = 16;
  localparam int unsigned DMA_ADDR_LSB   = 0;
endpackage

// ==== hw/irq_shape_if.sv ====
// carrier between the register bank and the edge interrupt shaper
// assumes both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface irq_shape_if;
  logic [15:0] pulse_length_clocks;
  logic [7:0]  min_width;
  logic        level_mode;
  logic        uframe_tick;
  logic        event_in;
  logic        irq;
  logic        pending;
  modport shaper (input pulse_length_clocks, min_width, level_mode, uframe_tick, event_in,
                  output irq, pending);
  modport ctrl   (output pulse_length_clocks, min_width, level_mode, uframe_tick, event_in,
                  input irq, pending);
endinterface
`default_nettype wire

// ==== hw/edge_irq_shaper.sv ====
// edge interrupt pulse generator with microframe spacing throttle
// assumes uframe_tick is a one-cycle pulse per 125 us microframe
`timescale 1ns/10ps
`default_nettype none
module edge_irq_shaper
  import irq_regs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     nrst,
  irq_shape_if.shaper   sh
);
  logic [15:0] pulse_cnt_reg;
  logic [15:0] pulse_cnt_next;
  logic [7:0]  gap_cnt_reg;
  logic        pending_reg;
  logic        irq_reg;
  logic        fire;
  logic [15:0] len_eff;

  // a zero length would swallow the event, so it still gives one clock
  assign len_eff = (sh.pulse_length_clocks == 16'h0000) ? 16'h0001 : sh.pulse_length_clocks;
  assign fire = !sh.level_mode && (pending_reg || sh.event_in)
                && (pulse_cnt_reg == 16'h0000) && (gap_cnt_reg == 8'h00);
  assign pulse_cnt_next = fire ? len_eff
                        : (pulse_cnt_reg != 16'h0000) ? pulse_cnt_reg - 16'h0001 : 16'h0000;
  assign sh.irq     = irq_reg;
  assign sh.pending = pending_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulse_cnt_reg <= 16'h0000;
      gap_cnt_reg   <= 8'h00;
      pending_reg   <= 1'b0;
      irq_reg       <= 1'b0;
    end
    else if (sh.level_mode)
    begin
      pulse_cnt_reg <= 16'h0000;
      gap_cnt_reg   <= 8'h00;
      pending_reg   <= 1'b0;
      irq_reg       <= sh.event_in;
    end
    else
    begin
      pulse_cnt_reg <= pulse_cnt_next;
      irq_reg       <= (pulse_cnt_next != 16'h0000);
      // a new event in the firing cycle is consumed by that pulse
      pending_reg   <= fire ? 1'b0 : (pending_reg || sh.event_in);
      if (fire)
        gap_cnt_reg <= sh.min_width;
      else if (sh.uframe_tick && gap_cnt_reg != 8'h00)
        gap_cnt_reg <= gap_cnt_reg - 8'h01;
    end
  end

  logic [15:0] hi_cnt;
  logic [15:0] len_cap;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hi_cnt  <= 16'h0000;
      len_cap <= 16'h0000;
    end
    else
    begin
      hi_cnt  <= irq_reg ? hi_cnt + 16'h0001 : 16'h0000;
      if (fire)
        len_cap <= len_eff;
    end
  end

  chk_pulse_width_exact: assert property (@(posedge clk) disable iff (!nrst)
    $fell(irq_reg) && !sh.level_mode && !$past(sh.level_mode)
    && $past(pulse_cnt_reg) == 16'h0001 |-> hi_cnt == len_cap)
    else $error("edge pulse width differs from programmed length");
  chk_spacing_gate: assert property (@(posedge clk) disable iff (!nrst)
    !sh.level_mode && gap_cnt_reg != 8'h00 && !irq_reg |=> !irq_reg)
    else $error("edge pulse issued inside minimum spacing");
  chk_gap_load: assert property (@(posedge clk) disable iff (!nrst)
    fire |=> gap_cnt_reg == $past(sh.min_width) && irq_reg)
    else $error("spacing counter not loaded on pulse");
  chk_zero_gap_immediate: assert property (@(posedge clk) disable iff (!nrst)
    !sh.level_mode && sh.event_in && sh.min_width == 8'h00 && gap_cnt_reg == 8'h00
    && pulse_cnt_reg == 16'h0000 |=> $rose(irq_reg))
    else $error("event with zero spacing not signalled at once");
  chk_level_follow: assert property (@(posedge clk) disable iff (!nrst)
    sh.level_mode |=> irq_reg == $past(sh.event_in) && gap_cnt_reg == 8'h00)
    else $error("level interrupt throttled or not following source");
  cov_back_to_back: cover property (@(posedge clk) disable iff (!nrst)
    $fell(irq_reg) ##1 fire);
  cov_throttled: cover property (@(posedge clk) disable iff (!nrst)
    pending_reg && gap_cnt_reg != 8'h00 ##[1:300] fire);
endmodule // edge_irq_shaper
`default_nettype wire

// ==== hw/irq_pulse_dma_power_regs.sv ====
// register bank: edge interrupt shaping, slave dma start address, power-down control
// assumes pin inputs synchronous to CLK_I; strobes active low; byte addresses
`timescale 1ns/10ps
`default_nettype none
module irq_pulse_dma_power_regs
  import irq_regs_pkg::*;
#(
  parameter int unsigned UFRAME_LEN = UFRAME_CYCLES
)
(
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CS_N_I,
  input  wire logic        RD_N_I,
  input  wire logic        WR_N_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic [31:0] DATA_I,
  output var  logic [31:0] DATA_O,
  input  wire logic        IRQ_EVENT_I,
  input  wire logic        IRQ_LEVEL_MODE_I,
  output var  logic        IRQ_O,
  output var  logic [15:0] DMA_START_ADDR_O,
  output var  logic [15:0] PD_CTRL_O,
  input  wire logic        SUSPEND_I,
  input  wire logic        WAKE_EVENT_I,
  output var  logic        AWAKE_O
);
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ofs);
    addr_is = (a[15:2] == ofs[15:2]);
  endfunction

  function automatic logic [31:0] masked(input logic [31:0] d, input logic [31:0] m,
                                         input logic [31:0] rst);
    masked = (d & m) | (rst & ~m);
  endfunction

  logic [31:0] edge_irq_shape_reg;
  logic [31:0] dma_start_address_reg;
  logic [31:0] power_down_control_reg;
  logic [31:0] data_o_reg;
  logic [31:0] rd_data;
  logic [13:0] uframe_div_reg;
  logic        uframe_tick_reg;
  logic [9:0]  slow_div_reg;
  logic        slow_tick_reg;
  logic [15:0] clk_off_cnt_reg;
  logic        awake_reg;
  logic        wr_en;
  logic        rd_en;
  logic        wr_shape;
  logic        wr_dma;
  logic        wr_pd;
  logic [15:0] clk_off_field;
  logic        wake_start;

  irq_shape_if shp ();

  assign wr_en    = !CS_N_I && !WR_N_I;
  assign rd_en    = !CS_N_I && !RD_N_I && WR_N_I;
  assign wr_shape = wr_en && addr_is(ADDR_I, EDGE_IRQ_SHAPE_OFS);
  assign wr_dma   = wr_en && addr_is(ADDR_I, DMA_START_OFS);
  assign wr_pd    = wr_en && addr_is(ADDR_I, POWER_DOWN_OFS);

  // dma start is write-only, so it and unmapped words read back as zero
  always_comb
  begin
    if (addr_is(ADDR_I, EDGE_IRQ_SHAPE_OFS))
      rd_data = edge_irq_shape_reg;
    else if (addr_is(ADDR_I, POWER_DOWN_OFS))
      rd_data = power_down_control_reg;
    else
      rd_data = 32'h0000_0000;
  end

  // reserved bits keep their reset value whatever software writes
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      edge_irq_shape_reg     <= EDGE_IRQ_SHAPE_RST;
      dma_start_address_reg  <= DMA_START_RST;
      power_down_control_reg <= POWER_DOWN_RST;
    end
    else
    begin
      if (wr_shape)
        edge_irq_shape_reg <= masked(DATA_I, EDGE_IRQ_SHAPE_WMSK, EDGE_IRQ_SHAPE_RST);
      if (wr_dma)
        dma_start_address_reg <= masked(DATA_I, DMA_START_WMSK, DMA_START_RST);
      if (wr_pd)
        power_down_control_reg <= masked(DATA_I, POWER_DOWN_WMSK, POWER_DOWN_RST);
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      data_o_reg <= 32'h0000_0000;
    else
      data_o_reg <= rd_en ? rd_data : 32'h0000_0000;
  end

  // microframe tick for the spacing counter
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      uframe_div_reg  <= 14'h0000;
      uframe_tick_reg <= 1'b0;
    end
    else
    begin
      uframe_tick_reg <= (uframe_div_reg == 14'(UFRAME_LEN - 1));
      uframe_div_reg  <= (uframe_div_reg == 14'(UFRAME_LEN - 1)) ? 14'h0000
                       : uframe_div_reg + 14'h0001;
    end
  end

  // slow 10 us tick stands in for the suspend clock, so its tolerance is not modelled
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      slow_div_reg  <= 10'h000;
      slow_tick_reg <= 1'b0;
    end
    else
    begin
      slow_tick_reg <= (slow_div_reg == 10'(SLOW_CYCLES - 1));
      slow_div_reg  <= (slow_div_reg == 10'(SLOW_CYCLES - 1)) ? 10'h000
                     : slow_div_reg + 10'h001;
    end
  end

  assign clk_off_field = power_down_control_reg[CLK_OFF_LSB +: 16];
  assign wake_start    = WAKE_EVENT_I && SUSPEND_I && !awake_reg
                         && (clk_off_field != 16'h0000);

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      awake_reg       <= 1'b0;
      clk_off_cnt_reg <= 16'h0000;
    end
    else if (wake_start)
    begin
      awake_reg       <= 1'b1;
      clk_off_cnt_reg <= clk_off_field;
    end
    else if (awake_reg)
    begin
      // software back to normal operation ends the wake window early
      if (!SUSPEND_I)
        awake_reg <= 1'b0;
      else if (slow_tick_reg)
      begin
        clk_off_cnt_reg <= clk_off_cnt_reg - 16'h0001;
        if (clk_off_cnt_reg == 16'h0001)
          awake_reg <= 1'b0;
      end
    end
  end

  assign shp.pulse_length_clocks = edge_irq_shape_reg[PULSE_LEN_LSB +: 16];
  assign shp.min_width           = edge_irq_shape_reg[MIN_WIDTH_LSB +: 8];
  assign shp.level_mode          = IRQ_LEVEL_MODE_I;
  assign shp.uframe_tick         = uframe_tick_reg;
  assign shp.event_in            = IRQ_EVENT_I;

  edge_irq_shaper u_shaper (
    .clk  (CLK_I),
    .nrst (NRST_I),
    .sh   (shp.shaper)
  );

  assign IRQ_O            = shp.irq;
  assign DATA_O           = data_o_reg;
  assign DMA_START_ADDR_O = dma_start_address_reg[DMA_ADDR_LSB +: 16];
  assign PD_CTRL_O        = power_down_control_reg[15:0];
  assign AWAKE_O          = awake_reg;

  chk_reset_pulse_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(NRST_I) |-> edge_irq_shape_reg[15:0] == 16'h000f)
    else $error("pulse length not fifteen after reset");
  chk_dma_addr_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_dma |=> DMA_START_ADDR_O == $past(DATA_I[15:0]))
    else $error("dma start address not taken from write");
  chk_dma_read_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    rd_en && addr_is(ADDR_I, DMA_START_OFS) |=> DATA_O == 32'h0000_0000)
    else $error("write-only dma register read back nonzero");
  chk_pd_readback: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_pd ##1 !wr_pd ##1 (rd_en && addr_is(ADDR_I, POWER_DOWN_OFS) && !wr_en)
    |=> DATA_O == masked($past(DATA_I, 3), POWER_DOWN_WMSK, POWER_DOWN_RST))
    else $error("power-down register readback mismatch");
  chk_never_wake_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    WAKE_EVENT_I && !awake_reg && clk_off_field == 16'h0000 |=> !awake_reg)
    else $error("woke up with clock-off count zero");
  chk_wake_count_step: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    awake_reg && SUSPEND_I && slow_tick_reg && !wake_start
    |=> clk_off_cnt_reg == $past(clk_off_cnt_reg) - 16'h0001)
    else $error("clock-off count not stepped on slow tick");
  chk_tick_spacing: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    slow_tick_reg |=> !slow_tick_reg [*8])
    else $error("slow tick spacing too short");
  cov_edge_pulse: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    !IRQ_LEVEL_MODE_I && $rose(IRQ_O));
  cov_wake_window: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(AWAKE_O));
  cov_dma_write: cover property (@(posedge CLK_I) disable iff (!NRST_I) wr_dma);
endmodule // irq_pulse_dma_power_regs
`default_nettype wire

// ==== testbench/host_bus_model.sv ====
// host processor model: drives the register port strobes, address and write data
// assumes active-low strobes sampled on the rising clock edge, one clock domain
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
(
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  output var  logic        cs_n_o,
  output var  logic        rd_n_o,
  output var  logic        wr_n_o,
  output var  logic [15:0] addr_o,
  output var  logic [31:0] wdata_o
);
  initial
  begin
    cs_n_o  = 1'b1;
    rd_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    addr_o  = 16'h0000;
    wdata_o = 32'h0000_0000;
  end

  // reserved bits go out as their reset values, whatever the caller passed
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [31:0] keep,
                    input logic [31:0] rst);
    @(negedge clk_i);
    cs_n_o  = 1'b0;
    wr_n_o  = 1'b0;
    addr_o  = a;
    wdata_o = (d & keep) | (rst & ~keep);
    @(negedge clk_i);
    cs_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    // released data must not look like the last word
    wdata_o = ~wdata_o;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] q);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    addr_o = a;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    q      = rdata_i;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ==== testbench/irq_pulse_dma_power_regs_bench.sv ====
// self-checking bench for the interrupt shaping, dma start and power-down registers
// assumes a shortened microframe of 20 clocks; inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module irq_pulse_dma_power_regs_bench;
  import irq_regs_pkg::*;
  logic        clk = 1'b0;
  logic        nrst;
  logic        cs_n, rd_n, wr_n;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, q;
  logic        ev, lvl, susp, wake, irq, awake;
  logic [15:0] dma, pd;
  int          mismatches = 0;
  int          n_compared = 0;
  int          dly, len;

  always #5 clk = ~clk;

  irq_pulse_dma_power_regs #(.UFRAME_LEN(20)) irq_pulse_dma_power_regs_inst (
    .CLK_I(clk), .NRST_I(nrst), .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
    .ADDR_I(addr), .DATA_I(wdata), .DATA_O(rdata), .IRQ_EVENT_I(ev),
    .IRQ_LEVEL_MODE_I(lvl), .IRQ_O(irq), .DMA_START_ADDR_O(dma), .PD_CTRL_O(pd),
    .SUSPEND_I(susp), .WAKE_EVENT_I(wake), .AWAKE_O(awake));

  host_bus_model host_bus_model_inst (
    .clk_i(clk), .rdata_i(rdata), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(addr), .wdata_o(wdata));

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic shape(input logic [31:0] d);
    host_bus_model_inst.wr(EDGE_IRQ_SHAPE_OFS, d, EDGE_IRQ_SHAPE_WMSK, EDGE_IRQ_SHAPE_RST);
  endtask

  task automatic pulse_event();
    @(negedge clk);
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
  endtask

  // wait for the interrupt to rise, then count how many clocks it stays high
  task automatic measure(input int lim);
    dly = 0;
    len = 0;
    while (irq !== 1'b1 && dly < lim)
    begin
      @(negedge clk);
      dly++;
    end
    while (irq === 1'b1 && len < 1000)
    begin
      @(negedge clk);
      len++;
    end
  endtask

  task automatic reset_values();
    host_bus_model_inst.rd(EDGE_IRQ_SHAPE_OFS, q);
    `CHK(q, 32'h0000_000f)
    host_bus_model_inst.rd(POWER_DOWN_OFS, q);
    `CHK(q, 32'h03e8_1ba0)
    `CHK(pd, 16'h1ba0)
    host_bus_model_inst.rd(16'h0348, q);
    `CHK(q, 32'h0000_0000)
  endtask

  task automatic dma_write_only();
    host_bus_model_inst.wr(DMA_START_OFS, 32'h0000_a5c3, DMA_START_WMSK, DMA_START_RST);
    `CHK(dma, 16'ha5c3)
    host_bus_model_inst.rd(DMA_START_OFS, q);
    `CHK(q, 32'h0000_0000)
  endtask

  task automatic pulse_lengths();
    pulse_event();
    measure(5);
    `CHK(len, 15)
    shape(32'h0000_0003);
    pulse_event();
    measure(5);
    `CHK(len, 3)
    pulse_event();
    measure(5);
    `CHK(dly, 0)
    `CHK(len, 3)
  endtask

  task automatic spacing();
    shape(32'h0200_0001);
    host_bus_model_inst.rd(EDGE_IRQ_SHAPE_OFS, q);
    `CHK(q, 32'h0200_0001)
    pulse_event();
    measure(60);
    `CHK(len, 1)
    pulse_event();
    measure(100);
    `CHK(dly >= 15 && dly <= 45, 1'b1)
  endtask

  task automatic level_mode();
    @(negedge clk);
    lvl = 1'b1;
    ev  = 1'b1;
    @(negedge clk);
    `CHK(irq, 1'b1)
    ev = 1'b0;
    @(negedge clk);
    `CHK(irq, 1'b0)
    ev = 1'b1;
    @(negedge clk);
    `CHK(irq, 1'b1)
    ev  = 1'b0;
    lvl = 1'b0;
  endtask

  task automatic wake_window(input logic [15:0] cnt);
    host_bus_model_inst.wr(POWER_DOWN_OFS, {cnt, 16'h079f}, POWER_DOWN_WMSK, POWER_DOWN_RST);
    host_bus_model_inst.rd(POWER_DOWN_OFS, q);
    `CHK(q, {cnt, 16'h079f})
    `CHK(pd, 16'h079f)
    @(negedge clk);
    susp = 1'b1;
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    len  = 0;
    while (awake === 1'b1 && len < 3000)
    begin
      @(negedge clk);
      len++;
    end
    susp = 1'b0;
  endtask

  initial
  begin
    {nrst, ev, lvl, susp, wake} = 5'h00;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    reset_values();
    dma_write_only();
    pulse_lengths();
    spacing();
    level_mode();
    wake_window(16'h0002);
    `CHK(len > 1000 && len <= 2001, 1'b1)
    wake_window(16'h0000);
    `CHK(len, 0)
    conclude();
  end

  initial
  begin
    #500000;
    mismatches++;
    conclude();
  end
endmodule // irq_pulse_dma_power_regs_bench
`default_nettype wire
